//--- src/esag_pkg.sv
/*
  Shared constants for the endian swap and access guard block.
  Assumes a 20 MHz core clock and a 32-bit register bus.
*/
package esag_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] ESAG_SE_DMA_CFG_OFF = 12'h048;
  localparam logic [11:0] ESAG_WIN0_OFF = 12'h070;
  localparam logic [11:0] ESAG_WIN5_OFF = 12'h084;
  localparam logic [11:0] ESAG_CPU_CFG_OFF = 12'h090;
  localparam logic [11:0] ESAG_SWAP_CTRL_OFF = 12'h100;
  localparam logic [11:0] ESAG_STATUS_OFF = 12'h104;
  localparam logic [11:0] ESAG_IRQ_MASK_OFF = 12'h108;
  localparam logic [3:0] ESAG_RING_PTR_NIB = 4'hC;
  localparam logic [7:0] ESAG_RING_PTR_TOP = 8'h03;
  localparam logic [11:0] ESAG_PTR_A_LO = 12'h0A0;
  localparam logic [11:0] ESAG_PTR_A_HI = 12'h0AC;
  localparam logic [11:0] ESAG_PTR_B_LO = 12'h0D0;
  localparam logic [11:0] ESAG_PTR_B_HI = 12'h0DC;
  localparam logic [31:0] ESAG_REG_RESET = 32'h0000_0000;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ESAG_WIN_OVR_BIT = 0;
  localparam int ESAG_CFG_FAST_WR_BIT = 0;
  localparam int ESAG_CFG_BURST_BIT = 1;
  localparam int ESAG_UNLOCK_LSB = 12;
  localparam int ESAG_NUM_WIN = 6;
  localparam int ESAG_NUM_SWAP = 5;
  localparam int ESAG_NUM_EVT = 8;
  localparam int ESAG_ADDR_W = 26;
  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0] {ESAG_KIND_DATA, ESAG_KIND_CMD, ESAG_KIND_DESC, ESAG_KIND_SWW}
    esag_kind_type;
  localparam logic [1:0] ESAG_UNLOCK_NONE = 2'h0;
  localparam logic [1:0] ESAG_UNLOCK_FULL = 2'h3;
  localparam logic [2:0] ESAG_UNIT_SEC_ENGINE = 3'h1;
  localparam logic [1:0] ESAG_RESP_OKAY = 2'h0;
  localparam logic [1:0] ESAG_RESP_SLVERR = 2'h2;
endpackage

//--- src/esag_core.sv
/*
  Endian swap units, window endianness override and protected-mode host filter.
  Assumes the local processor reaches the registers over AXI4-Lite, that all
  request inputs are synchronous to clk_sys and that one host request is open at a time.
*/
`timescale 1ns/10ps
// How it works
// - Local processor sees this block as a 32-bit memory-mapped slave only.
// - Fast writes and sub-block bursts are enabled by config register bits.
// - Software-selected local processor events raise the processor interrupt.
// - Packet memory stays little-endian; reordering only inside swap units.
// - Each swap unit has its own enable from registers, flags and pin.
// - DMA swapping is chosen per data, command, descriptor and single word write.
// - An enabled swap unit reverses the four bytes of each word.
// - A disabled swap unit passes the word unchanged.
// - Packet memory addresses are 26 bits, covering 64MB.
// - Packet memory regions can be kept out of host reach.
// - Context memory is granted only to the security engine, 64MB range.
// - Protect pin selects mode; unprotected host reaches everything.
// - Protected host writes to hidden registers drop, reads give zero.
// - Protected packet memory is locked unless unlock bits 13:12 open it.
// - Buffer and ring pointer registers stay host reachable when protected.
// - Local processor always has full access to everything.
// - All registers except the pointer registers are hidden from the host when protected.
module esag_core
#(
  parameter int ADDR_W = esag_pkg::ESAG_ADDR_W
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_endian_select,
  input wire logic protect_n,
  input wire logic [esag_pkg::ESAG_NUM_EVT-1:0] cpu_event,
  output logic cpu_irq,
  output logic cpu_fast_write_en,
  output logic cpu_burst_en,
  input wire logic [2:0] cpu_win_sel,
  input wire logic [esag_pkg::ESAG_NUM_SWAP-1:0] swp_valid,
  input wire logic [esag_pkg::ESAG_NUM_SWAP*32-1:0] swp_data,
  input wire logic [esag_pkg::ESAG_NUM_SWAP*2-1:0] swp_kind,
  input wire logic [esag_pkg::ESAG_NUM_SWAP-1:0] swp_flag,
  output logic [esag_pkg::ESAG_NUM_SWAP-1:0] swp_out_valid,
  output logic [esag_pkg::ESAG_NUM_SWAP*32-1:0] swp_out_data,
  input wire logic host_req_valid,
  input wire logic host_req_write,
  input wire logic host_req_is_ram,
  input wire logic host_req_group,
  input wire logic [ADDR_W-1:0] host_req_addr,
  input wire logic [31:0] host_req_wdata,
  output logic fwd_valid,
  output logic fwd_write,
  output logic fwd_is_ram,
  output logic fwd_group,
  output logic [ADDR_W-1:0] fwd_addr,
  output logic [31:0] fwd_wdata,
  input wire logic int_rvalid,
  input wire logic [31:0] int_rdata,
  output logic host_rvalid,
  output logic [31:0] host_rdata,
  output logic host_blocked,
  input wire logic ctx_req_valid,
  input wire logic [2:0] ctx_req_unit,
  input wire logic [ADDR_W-1:0] ctx_req_addr,
  output logic ctx_grant,
  output logic [ADDR_W-1:0] ctx_addr
);
  import esag_pkg::*;

  // ************************************************************
  // Register bus slave
  // ************************************************************
  logic [11:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] win_reg [ESAG_NUM_WIN];
  logic [31:0] local_cpu_config_reg;
  logic [31:0] se_dma_cfg_reg;
  logic [31:0] swap_ctrl_reg;
  logic [ESAG_NUM_EVT-1:0] irq_mask_reg;
  logic cpu_irq_reg;

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire [11:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_fire = (aw_held_reg | aw_take) & (w_held_reg | w_take) & ~bvalid_reg;
  wire rd_fire = s_axi_arvalid & s_axi_arready;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_win(input logic [11:0] a);
    return (a >= ESAG_WIN0_OFF) && (a <= ESAG_WIN5_OFF) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return is_win(a) || a == ESAG_SE_DMA_CFG_OFF || a == ESAG_CPU_CFG_OFF ||
           a == ESAG_SWAP_CTRL_OFF || a == ESAG_STATUS_OFF || a == ESAG_IRQ_MASK_OFF;
  endfunction

  wire [2:0] wr_win = 3'((wr_addr - ESAG_WIN0_OFF) >> 2);
  wire [2:0] rd_win = 3'((s_axi_araddr - ESAG_WIN0_OFF) >> 2);
  wire protect_mode = ~protect_n;

  logic [31:0] rd_value;
  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (is_win(s_axi_araddr))
    begin
      rd_value = win_reg[rd_win];
    end
    else if (s_axi_araddr == ESAG_SE_DMA_CFG_OFF)
    begin
      rd_value = se_dma_cfg_reg;
    end
    else if (s_axi_araddr == ESAG_CPU_CFG_OFF)
    begin
      rd_value = local_cpu_config_reg;
    end
    else if (s_axi_araddr == ESAG_SWAP_CTRL_OFF)
    begin
      rd_value = swap_ctrl_reg;
    end
    else if (s_axi_araddr == ESAG_STATUS_OFF)
    begin
      rd_value = {29'h0, cpu_irq_reg, cpu_endian_select, protect_mode};
    end
    else if (s_axi_araddr == ESAG_IRQ_MASK_OFF)
    begin
      rd_value = {24'h0, irq_mask_reg};
    end
  end

  // The local processor is never filtered, whatever the protect pin says.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= ESAG_REG_RESET;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ESAG_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= ESAG_RESP_OKAY;
      rdata_reg <= ESAG_REG_RESET;
      local_cpu_config_reg <= ESAG_REG_RESET;
      se_dma_cfg_reg <= ESAG_REG_RESET;
      swap_ctrl_reg <= ESAG_REG_RESET;
      irq_mask_reg <= 8'h00;
      for (int i = 0; i < ESAG_NUM_WIN; i++)
      begin
        win_reg[i] <= ESAG_REG_RESET;
      end
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(wr_addr) ? ESAG_RESP_OKAY : ESAG_RESP_SLVERR;
        if (is_win(wr_addr))
        begin
          win_reg[wr_win] <= merge(win_reg[wr_win], wr_data, wr_strb);
        end
        if (wr_addr == ESAG_SE_DMA_CFG_OFF)
        begin
          se_dma_cfg_reg <= merge(se_dma_cfg_reg, wr_data, wr_strb);
        end
        if (wr_addr == ESAG_CPU_CFG_OFF)
        begin
          local_cpu_config_reg <= merge(local_cpu_config_reg, wr_data, wr_strb);
        end
        if (wr_addr == ESAG_SWAP_CTRL_OFF)
        begin
          swap_ctrl_reg <= merge(swap_ctrl_reg, wr_data, wr_strb);
        end
        if (wr_addr == ESAG_IRQ_MASK_OFF && wr_strb[0])
        begin
          irq_mask_reg <= wr_data[7:0];
        end
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
        end
        if (w_take)
        begin
          w_held_reg <= 1'b1;
          wdata_reg <= s_axi_wdata;
          wstrb_reg <= s_axi_wstrb;
        end
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
      if (rd_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_value;
        rresp_reg <= mapped(s_axi_araddr) ? ESAG_RESP_OKAY : ESAG_RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Local processor options and interrupt
  // ************************************************************
  assign cpu_fast_write_en = local_cpu_config_reg[ESAG_CFG_FAST_WR_BIT];
  assign cpu_burst_en = local_cpu_config_reg[ESAG_CFG_BURST_BIT];
  assign cpu_irq = cpu_irq_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cpu_irq_reg <= 1'b0;
    end
    else
    begin
      cpu_irq_reg <= |(cpu_event & irq_mask_reg);
    end
  end

  // ************************************************************
  // Byte swap units
  // ************************************************************
  // Lanes 0 and 1 are the general and security engine DMA paths, lane 2 the
  // local processor path, lanes 3 and 4 plain register- and flag-controlled paths.
  wire win_ovr = (cpu_win_sel < 3'(ESAG_NUM_WIN)) ? win_reg[cpu_win_sel][ESAG_WIN_OVR_BIT] : 1'b0;
  wire cpu_swap = cpu_endian_select ^ win_ovr;

  generate
    for (genvar g = 0; g < ESAG_NUM_SWAP; g++)
    begin : g_swap
      wire [31:0] din = swp_data[g*32 +: 32];
      wire [1:0] kind = swp_kind[g*2 +: 2];
      wire en;
      if (g < 2)
      begin : g_dma
        assign en = swap_ctrl_reg[g*4 + int'(kind)] ^ swp_flag[g];
      end
      else if (g == 2)
      begin : g_cpu
        assign en = cpu_swap;
      end
      else
      begin : g_reg
        assign en = swap_ctrl_reg[8 + g] ^ swp_flag[g];
      end
      wire [31:0] swapped = {din[7:0], din[15:8], din[23:16], din[31:24]};
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          swp_out_valid[g] <= 1'b0;
          swp_out_data[g*32 +: 32] <= ESAG_REG_RESET;
        end
        else
        begin
          swp_out_valid[g] <= swp_valid[g];
          if (swp_valid[g])
          begin
            swp_out_data[g*32 +: 32] <= en ? swapped : din;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Protected-mode host filter
  // ************************************************************
  // Pointer registers stay open so the host can still hand over buffers.
  wire [11:0] ha = host_req_addr[11:0];
  wire reg_open = host_req_group &&
                  ((ha[3:0] == ESAG_RING_PTR_NIB && ha[11:4] <= ESAG_RING_PTR_TOP) ||
                   (ha >= ESAG_PTR_A_LO && ha <= ESAG_PTR_A_HI) ||
                   (ha >= ESAG_PTR_B_LO && ha <= ESAG_PTR_B_HI));
  wire [1:0] unlock = se_dma_cfg_reg[ESAG_UNLOCK_LSB +: 2];
  // Partial unlock opens the upper half of the 64MB space only.
  wire ram_open = (unlock == ESAG_UNLOCK_FULL) ||
                  (unlock != ESAG_UNLOCK_NONE && host_req_addr[ADDR_W-1]);
  wire hide = protect_mode && (host_req_is_ram ? ~ram_open : ~reg_open);

  logic fwd_valid_reg;
  logic fwd_write_reg;
  logic fwd_is_ram_reg;
  logic fwd_group_reg;
  logic [ADDR_W-1:0] fwd_addr_reg;
  logic [31:0] fwd_wdata_reg;
  logic host_rvalid_reg;
  logic [31:0] host_rdata_reg;
  logic host_blocked_reg;
  logic ctx_grant_reg;
  logic [ADDR_W-1:0] ctx_addr_reg;

  assign fwd_valid = fwd_valid_reg;
  assign fwd_write = fwd_write_reg;
  assign fwd_is_ram = fwd_is_ram_reg;
  assign fwd_group = fwd_group_reg;
  assign fwd_addr = fwd_addr_reg;
  assign fwd_wdata = fwd_wdata_reg;
  assign host_rvalid = host_rvalid_reg;
  assign host_rdata = host_rdata_reg;
  assign host_blocked = host_blocked_reg;
  assign ctx_grant = ctx_grant_reg;
  assign ctx_addr = ctx_addr_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fwd_valid_reg <= 1'b0;
      fwd_write_reg <= 1'b0;
      fwd_is_ram_reg <= 1'b0;
      fwd_group_reg <= 1'b0;
      fwd_addr_reg <= '0;
      fwd_wdata_reg <= ESAG_REG_RESET;
      host_rvalid_reg <= 1'b0;
      host_rdata_reg <= ESAG_REG_RESET;
      host_blocked_reg <= 1'b0;
      ctx_grant_reg <= 1'b0;
      ctx_addr_reg <= '0;
    end
    else
    begin
      fwd_valid_reg <= host_req_valid & ~hide;
      host_blocked_reg <= host_req_valid & hide;
      if (host_req_valid)
      begin
        fwd_write_reg <= host_req_write;
        fwd_is_ram_reg <= host_req_is_ram;
        fwd_group_reg <= host_req_group;
        fwd_addr_reg <= host_req_addr;
        fwd_wdata_reg <= host_req_wdata;
      end
      // A hidden read is answered here with zero and never reaches the device.
      host_rvalid_reg <= int_rvalid | (host_req_valid & hide & ~host_req_write);
      if (host_req_valid && hide && !host_req_write)
      begin
        host_rdata_reg <= 32'h0000_0000;
      end
      else if (int_rvalid)
      begin
        host_rdata_reg <= int_rdata;
      end
      ctx_grant_reg <= ctx_req_valid && (ctx_req_unit == ESAG_UNIT_SEC_ENGINE);
      if (ctx_req_valid)
      begin
        ctx_addr_reg <= ctx_req_addr;
      end
    end
  end
endmodule

//--- dv/esag_checker.sv
/*
  Port checker for esag_core, bound to every instance.
  Assumes one clk_sys domain with synchronous sys_rst.
*/
`timescale 1ns/10ps
module esag_checker
  import esag_pkg::*;
#(
  parameter int ADDR_W = 26
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cpu_endian_select,
  input wire logic protect_n,
  input wire logic [2:0] cpu_win_sel,
  input wire logic [4:0] swp_valid,
  input wire logic [159:0] swp_data,
  input wire logic [4:0] swp_out_valid,
  input wire logic [159:0] swp_out_data,
  input wire logic host_req_valid,
  input wire logic host_req_write,
  input wire logic host_req_is_ram,
  input wire logic host_req_group,
  input wire logic [ADDR_W-1:0] host_req_addr,
  input wire logic fwd_valid,
  input wire logic [ADDR_W-1:0] fwd_addr,
  input wire logic int_rvalid,
  input wire logic [31:0] int_rdata,
  input wire logic host_rvalid,
  input wire logic [31:0] host_rdata,
  input wire logic host_blocked,
  input wire logic ctx_req_valid,
  input wire logic [2:0] ctx_req_unit,
  input wire logic [ADDR_W-1:0] ctx_req_addr,
  input wire logic ctx_grant,
  input wire logic [ADDR_W-1:0] ctx_addr
);
  logic [31:0] lane2_in;
  logic [31:0] lane2_sw;
  assign lane2_in = swp_data[95:64];
  assign lane2_sw = {lane2_in[7:0], lane2_in[15:8], lane2_in[23:16], lane2_in[31:24]};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_hidden_req;
    host_req_valid && !protect_n && !host_req_is_ram && !host_req_group;
  endsequence
  sequence s_zero_answer;
    host_blocked && host_rvalid && host_rdata == 32'h0000_0000;
  endsequence
  a_swap_valid:
    assert property (swp_valid != 5'h00 |=> swp_out_valid == $past(swp_valid))
    else $error("Swap valid not passed on");
  a_lane2_order:
    assert property (swp_valid[2] && cpu_win_sel > 3'h5 |=> swp_out_data[95:64] ==
      ($past(cpu_endian_select) ? $past(lane2_sw) : $past(lane2_in)))
    else $error("Lane two byte order wrong");
  a_open_pass:
    assert property (host_req_valid && protect_n |=> fwd_valid && !host_blocked &&
      fwd_addr == $past(host_req_addr))
    else $error("Open request not forwarded");
  a_hidden_read:
    assert property (s_hidden_req ##0 !host_req_write |=> s_zero_answer)
    else $error("Hidden read not zero");
  a_hidden_write:
    assert property (s_hidden_req ##0 host_req_write |=> host_blocked && !fwd_valid)
    else $error("Hidden write not dropped");
  a_one_answer:
    assert property (host_req_valid |=> fwd_valid != host_blocked)
    else $error("Host request answer wrong");
  a_read_return:
    assert property (int_rvalid |=> host_rvalid && host_rdata == $past(int_rdata))
    else $error("Read data not returned");
  a_ctx_grant:
    assert property (ctx_req_valid && ctx_req_unit == ESAG_UNIT_SEC_ENGINE |=>
      ctx_grant && ctx_addr == $past(ctx_req_addr))
    else $error("Engine context request not granted");
  a_ctx_deny:
    assert property (ctx_req_valid && ctx_req_unit != ESAG_UNIT_SEC_ENGINE |=> !ctx_grant)
    else $error("Context granted to other unit");
endmodule
bind esag_core esag_checker #(.ADDR_W(ADDR_W)) u_checker (.clk_sys, .sys_rst,
  .cpu_endian_select, .protect_n, .cpu_win_sel, .swp_valid, .swp_data, .swp_out_valid,
  .swp_out_data, .host_req_valid, .host_req_write, .host_req_is_ram, .host_req_group,
  .host_req_addr, .fwd_valid, .fwd_addr, .int_rvalid, .int_rdata, .host_rvalid,
  .host_rdata, .host_blocked, .ctx_req_valid, .ctx_req_unit, .ctx_req_addr, .ctx_grant,
  .ctx_addr);

//--- dv/esag_int_model.sv
/*
  Device internals answering reads that the guard forwards.
  Assumes clk_sys and sys_rst of the guard.
*/
`timescale 1ns/10ps
module esag_int_model
#(
  parameter int ADDR_W = 26
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic fwd_valid,
  input wire logic fwd_write,
  input wire logic [ADDR_W-1:0] fwd_addr,
  output logic int_rvalid,
  output logic [31:0] int_rdata
);
  logic pend_reg;
  logic [1:0] wait_reg;
  logic [31:0] data_reg;
  // Idle data toggles so that a stale word is never taken for an answer.
  always_ff @(posedge clk_sys)
  begin
    int_rvalid <= 1'h0;
    int_rdata <= ~int_rdata;
    if (sys_rst)
    begin
      pend_reg <= 1'h0;
      wait_reg <= 2'h0;
      int_rdata <= 32'h0000_0000;
    end
    else if (fwd_valid && !fwd_write)
    begin
      pend_reg <= 1'h1;
      wait_reg <= slow ? 2'h3 : 2'h0;
      data_reg <= 32'(fwd_addr) ^ 32'hA5A5_0000;
    end
    else if (wait_reg != 2'h0)
      wait_reg <= wait_reg - 2'h1;
    else if (pend_reg)
    begin
      pend_reg <= 1'h0;
      int_rvalid <= 1'h1;
      int_rdata <= data_reg;
    end
  end
endmodule

//--- dv/esag_core_tb.sv
/*
  Self-checking bench for the endian swap and access guard.
  Assumes the checker and the internals model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); \
    end \
  end
module esag_core_tb;
  import esag_pkg::*;
  localparam logic [31:0] CTRL = 32'h0000_0845;
  int failures = 0;
  int check_count = 0;
  logic clk_sys = 1'h0, sys_rst = 1'h1, slow = 1'h0, protect_n = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_endian_select = 1'h0;
  logic host_req_valid = 1'h0, host_req_write = 1'h0, host_req_is_ram = 1'h0;
  logic host_req_group = 1'h0, ctx_req_valid = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, host_req_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] cpu_event = 8'h00;
  logic [2:0] cpu_win_sel = 3'h7, ctx_req_unit = 3'h0;
  logic [4:0] swp_valid = 5'h00, swp_flag = 5'h00;
  logic [159:0] swp_data = 160'h0;
  logic [9:0] swp_kind = 10'h000;
  logic [25:0] host_req_addr = 26'h0, ctx_req_addr = 26'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_irq;
  logic cpu_fast_write_en, cpu_burst_en, fwd_valid, fwd_write, fwd_is_ram, fwd_group;
  logic int_rvalid, host_rvalid, host_blocked, ctx_grant;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, fwd_wdata, int_rdata, host_rdata, d, u;
  logic [4:0] swp_out_valid;
  logic [159:0] swp_out_data;
  logic [25:0] fwd_addr, ctx_addr;
  always #25 clk_sys = ~clk_sys;
  esag_core u_dut (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_endian_select, .protect_n, .cpu_event,
    .cpu_irq, .cpu_fast_write_en, .cpu_burst_en, .cpu_win_sel, .swp_valid, .swp_data,
    .swp_kind, .swp_flag, .swp_out_valid, .swp_out_data, .host_req_valid, .host_req_write,
    .host_req_is_ram, .host_req_group, .host_req_addr, .host_req_wdata, .fwd_valid,
    .fwd_write, .fwd_is_ram, .fwd_group, .fwd_addr, .fwd_wdata, .int_rvalid, .int_rdata,
    .host_rvalid, .host_rdata, .host_blocked, .ctx_req_valid, .ctx_req_unit, .ctx_req_addr,
    .ctx_grant, .ctx_addr);
  esag_int_model u_model (.clk_sys, .sys_rst, .slow, .fwd_valid, .fwd_write, .fwd_addr,
    .int_rvalid, .int_rdata);
  task automatic results();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] q);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    q = s_axi_bresp;
    @(posedge clk_sys);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] q);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    q = s_axi_rresp;
    @(posedge clk_sys);
  endtask
  task automatic host_op(input logic w, m, g, input logic [25:0] a, input logic f);
    host_req_write <= w;
    host_req_is_ram <= m;
    host_req_group <= g;
    host_req_addr <= a;
    host_req_wdata <= ~32'(a);
    host_req_valid <= 1'h1;
    @(posedge clk_sys);
    host_req_valid <= 1'h0;
    host_req_addr <= ~a;
    #1;
    `CHK({fwd_valid, host_blocked}, {f, !f})
    if (f)
      `CHK({fwd_write, fwd_is_ram, fwd_group, fwd_addr, fwd_wdata}, {w, m, g, a, ~32'(a)})
    if (!w && f)
    begin
      for (int n = 0; n < 12 && host_rvalid !== 1'h1; n++)
        @(posedge clk_sys) #1;
      `CHK({host_rvalid, host_rdata}, {1'h1, 32'(a) ^ 32'hA5A5_0000})
    end
    else if (!w)
      `CHK({host_rvalid, host_rdata}, 33'h1_0000_0000)
    @(posedge clk_sys);
  endtask
  task automatic swap_chk(input logic [1:0] k, input logic [4:0] fl, input logic e2);
    logic en;
    logic [31:0] v;
    for (int g = 0; g < 5; g++)
    begin
      swp_data[g*32+:32] <= 32'h1122_3340 + g;
      swp_kind[g*2+:2] <= k;
    end
    swp_flag <= fl;
    swp_valid <= 5'h1F;
    @(posedge clk_sys);
    swp_valid <= 5'h00;
    swp_data <= ~swp_data;
    #1;
    `CHK(swp_out_valid, 5'h1F)
    for (int g = 0; g < 5; g++)
    begin
      v = 32'h1122_3340 + g;
      en = (g == 2) ? e2 : (g < 2 ? CTRL[g*4+k] : CTRL[8+g]) ^ fl[g];
      `CHK(swp_out_data[g*32+:32], en ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v)
    end
    @(posedge clk_sys);
  endtask
  initial
  begin
    do_reset();
    `CHK({s_axi_awready, s_axi_bvalid}, 2'h2)
    axi_rd(ESAG_CPU_CFG_OFF, d, r);
    `CHK(d, ESAG_REG_RESET)
    axi_wr(ESAG_CPU_CFG_OFF, 32'h0000_0003, r);
    `CHK({cpu_burst_en, cpu_fast_write_en, r}, {2'h3, ESAG_RESP_OKAY})
    axi_wr(12'hFFC, 32'h0000_0001, r);
    `CHK(r, ESAG_RESP_SLVERR)
    axi_rd(12'hFFC, d, r);
    `CHK({r, d}, {ESAG_RESP_SLVERR, 32'h0})
    axi_wr(ESAG_IRQ_MASK_OFF, 32'h0000_0001, r);
    cpu_event <= 8'h02;
    repeat (2) @(posedge clk_sys);
    `CHK(cpu_irq, 1'h0)
    cpu_event <= 8'h01;
    repeat (2) @(posedge clk_sys);
    `CHK(cpu_irq, 1'h1)
    axi_rd(ESAG_STATUS_OFF, d, r);
    `CHK({r, d}, {ESAG_RESP_OKAY, 32'h0000_0004})
    cpu_event <= 8'h00;
    host_op(1'h0, 1'h0, 1'h0, 26'h0000004, 1'h1);
    host_op(1'h1, 1'h1, 1'h0, 26'h0000100, 1'h1);
    slow <= 1'h1;
    host_op(1'h0, 1'h0, 1'h1, 26'h0000048, 1'h1);
    slow <= 1'h0;
    // The protect pin only moves while the device is held in reset.
    protect_n <= 1'h0;
    do_reset();
    host_op(1'h0, 1'h0, 1'h0, 26'h0000004, 1'h0);
    host_op(1'h1, 1'h0, 1'h1, 26'h0000048, 1'h0);
    host_op(1'h1, 1'h0, 1'h1, 26'h000000C, 1'h1);
    host_op(1'h0, 1'h0, 1'h1, 26'h00000D4, 1'h1);
    host_op(1'h0, 1'h1, 1'h0, 26'h2000040, 1'h0);
    for (u = 32'h1; u < 32'h4; u++)
    begin
      axi_wr(ESAG_SE_DMA_CFG_OFF, u << ESAG_UNLOCK_LSB, r);
      axi_rd(ESAG_SE_DMA_CFG_OFF, d, r);
      `CHK(d, u << ESAG_UNLOCK_LSB)
      host_op(1'h0, 1'h1, 1'h0, 26'h2000040, 1'h1);
      host_op(1'h1, 1'h1, 1'h0, 26'h0000040, u == 32'h3);
    end
    for (u = 32'h0; u < 32'h3; u++)
    begin
      ctx_req_valid <= 1'h1;
      ctx_req_unit <= u[2:0];
      ctx_req_addr <= 26'h3FFFFFF - u[25:0];
      @(posedge clk_sys);
      ctx_req_valid <= 1'h0;
      #1;
      `CHK(ctx_grant, u == 32'h1)
      @(posedge clk_sys);
    end
    axi_wr(ESAG_SWAP_CTRL_OFF, CTRL, r);
    for (u = 32'h0; u < 32'h4; u++)
    begin
      swap_chk(u[1:0], 5'h00, 1'h0);
      swap_chk(u[1:0], 5'h0B, 1'h0);
    end
    axi_wr(ESAG_WIN0_OFF + 12'h00C, 32'h0000_0001, r);
    for (u = 32'h0; u < 32'h6; u++)
    begin
      cpu_endian_select <= u[0];
      cpu_win_sel <= {1'h0, u[2:1]} + 3'h2;
      swap_chk(2'h0, 5'h00, u[0] ^ (u[2:1] == 2'h1));
    end
    cpu_win_sel <= 3'h6;
    swap_chk(2'h0, 5'h00, 1'h1);
    results();
  end
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    results();
  end
endmodule
